//--- logic/otpsh_pkg.sv
// Purpose: shared types and constants of the otp space and register shadow block
// Assumes: one clock, byte wide command port from logic on the same clock
// Notes: register indices below are the command port addresses of the registers

package otpsh_pkg;

  // otp space layout
  localparam int OTP_BYTES = 1024;
  localparam int OTP_AW = 10;
  localparam int RGN_LSB = 5;
  localparam int RNG_BYTES = 16;
  localparam logic [9:0] LOCK_BASE = 10'h010;
  localparam logic [7:0] ERASED = 8'hff;

  // register shadow layout
  localparam int REG_CNT = 21;
  localparam logic [7:0] NV_FACTORY = 8'h00;
  localparam int FRZ_BIT = 0;
  localparam int PERR_BIT = 6;

  localparam logic [4:0] IDX_SR1 = 5'h00;
  localparam logic [4:0] IDX_SR2 = 5'h01;
  localparam logic [4:0] IDX_CR1 = 5'h02;
  localparam logic [4:0] IDX_CR2 = 5'h03;
  localparam logic [4:0] IDX_CR3 = 5'h04;
  localparam logic [4:0] IDX_CR4 = 5'h05;
  localparam logic [4:0] IDX_ECC = 5'h06;
  localparam logic [4:0] IDX_ASP_LO = 5'h07;
  localparam logic [4:0] IDX_ASP_HI = 5'h08;
  localparam logic [4:0] IDX_PASS0 = 5'h09;
  localparam logic [4:0] IDX_PASS7 = 5'h10;
  localparam logic [4:0] IDX_PERSISTENT_PROTECT_LOCK = 5'h11;
  localparam logic [4:0] IDX_PERSISTENT_PROTECT_ACCESS = 5'h12;
  localparam logic [4:0] IDX_DYNAMIC_PROTECT_ACCESS = 5'h13;
  localparam logic [4:0] IDX_DLR = 5'h14;

  typedef enum logic [1:0] {
    K_DUAL = 2'h0,
    K_VOL = 2'h1,
    K_NV = 2'h2,
    K_OTP = 2'h3
  } otpsh_kind_t;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_OTP_RD = 3'h1,
    OP_OTP_PRG = 3'h2,
    OP_REG_RD = 3'h3,
    OP_REG_RD_NV = 3'h4,
    OP_REG_WR_NV = 3'h5,
    OP_REG_WR_V = 3'h6,
    OP_REG_PRG = 3'h7
  } otpsh_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1
  } otpsh_state_t;

  typedef struct packed {
    otpsh_op_t op;
    logic [9:0] addr;
    logic [7:0] data;
  } otpsh_cmd_t;

  typedef struct packed {
    logic fail;
    logic [7:0] data;
  } otpsh_rsp_t;

endpackage : otpsh_pkg

//--- logic/otpsh_top.sv
// Purpose: otp byte space with region locks and freeze, plus nv/volatile register shadows
// Assumes: commands come from logic on SYS_CLK_I; the hardware reset pin is asynchronous
// Notes: RST_N_I models first power-up of a shipped part and loads factory contents
//
// Summary of operation
// - separate 1024 byte otp space from zero
// - 32 regions of 32 bytes, each lockable
// - random bytes 0..15 ignore programmed ones
// - programming a zero there fails, sets error
// - lock bytes 0x10..0x13 block region programming
// - region n lock is bit n, zero locks
// - reserved bytes ship erased and stay programmable
// - regions 1..31 ship erased, host programmable
// - freeze bit rejects all otp programming
// - reading dual register returns volatile copy
// - dual copies for volatile or fast registers
// - every reset copies nonvolatile into volatile
// - nv write replaces nv, refreshes volatile
// - otp register program ands nv copy, and volatile copy of dual registers only
// - volatile write touches only volatile copy
// - volatile defaults after reset, nv keeps value
// - program error flag is status one bit 6

`timescale 1ns/1ps

module otpsh_top #(
  // arbitrary neutral factory random number
  parameter logic [127:0] FACTORY_RANDOM = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  // clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  // reset sources
  input wire logic HW_RESET_N_I,
  input wire logic SOFT_RESET_I,
  // command port
  input wire logic CMD_VALID_I,
  input wire otpsh_pkg::otpsh_cmd_t CMD_I,
  // answer port
  output logic RSP_VALID_O,
  output otpsh_pkg::otpsh_rsp_t RSP_O,
  output logic BUSY_O,
  // status
  output logic FREEZE_O,
  output logic PROG_ERR_O
);
  import otpsh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decode functions

  function automatic otpsh_kind_t reg_kind(input logic [4:0] idx);
    otpsh_kind_t k;
    k = K_DUAL;
    if (idx == IDX_SR2 || idx == IDX_ECC || idx == IDX_PERSISTENT_PROTECT_LOCK || idx == IDX_DYNAMIC_PROTECT_ACCESS) begin
      k = K_VOL;
    end else if (idx == IDX_PERSISTENT_PROTECT_ACCESS) begin
      k = K_NV;
    end else if (idx >= IDX_ASP_LO && idx <= IDX_PASS7) begin
      k = K_OTP;
    end
    return k;
  endfunction : reg_kind

  function automatic logic has_v(input otpsh_kind_t k);
    return (k == K_DUAL) || (k == K_VOL);
  endfunction : has_v

  function automatic logic has_nv(input otpsh_kind_t k);
    return k != K_VOL;
  endfunction : has_nv

  function automatic logic [7:0] reg_factory(input otpsh_kind_t k);
    return (k == K_OTP) ? ERASED : NV_FACTORY;
  endfunction : reg_factory

  function automatic logic [7:0] otp_factory(input logic [9:0] a);
    logic [127:0] sh;
    sh = FACTORY_RANDOM >> {a[3:0], 3'h0};
    return (a < 10'(RNG_BYTES)) ? sh[7:0] : ERASED;
  endfunction : otp_factory

  function automatic logic [9:0] lock_addr(input logic [4:0] rgn);
    return LOCK_BASE + {8'h00, rgn[4:3]};
  endfunction : lock_addr

  ////////////////////////////////////////////////////////////////////////
  // hardware reset pin synchroniser

  logic hwr_s1_q;
  logic hwr_s2_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      hwr_s1_q <= 1'b1;
      hwr_s2_q <= 1'b1;
    end else if (CLK_EN_I) begin
      hwr_s1_q <= HW_RESET_N_I;
      hwr_s2_q <= hwr_s1_q;
    end
  end

  logic rst_evt;
  assign rst_evt = SOFT_RESET_I || !hwr_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // reload sequencer

  otpsh_state_t st_q;
  otpsh_state_t st_d;

  // a reset source held active keeps the block in reload
  always_comb begin
    case (st_q)
      ST_IDLE: st_d = rst_evt ? ST_LOAD : ST_IDLE;
      ST_LOAD: st_d = rst_evt ? ST_LOAD : ST_IDLE;
      default: st_d = ST_LOAD;
    endcase
  end

  // power-on starts with one reload cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      st_q <= ST_LOAD;
      BUSY_O <= 1'b1;
    end else if (CLK_EN_I) begin
      st_q <= st_d;
      BUSY_O <= (st_d == ST_LOAD);
    end
  end

  logic loading;
  assign loading = (st_q == ST_LOAD);

  ////////////////////////////////////////////////////////////////////////
  // command decode

  logic acc;
  otpsh_op_t op;
  logic [9:0] addr;
  logic [7:0] data;

  assign acc = CMD_VALID_I && CLK_EN_I && !loading;
  assign op = CMD_I.op;
  assign addr = CMD_I.addr;
  assign data = CMD_I.data;

  logic [7:0] otp_q [OTP_BYTES];
  logic [7:0] nv_q [REG_CNT];
  logic [7:0] v_q [REG_CNT];

  logic frz;
  assign frz = v_q[IDX_CR1][FRZ_BIT];

  // otp program checks
  logic [4:0] rgn;
  logic [7:0] lock_byte;
  logic locked;
  logic in_rng;
  logic otp_prg;
  logic otp_fail;
  logic otp_wr;

  assign rgn = addr[OTP_AW-1:RGN_LSB];
  assign lock_byte = otp_q[lock_addr(rgn)];
  assign locked = !lock_byte[rgn[2:0]];
  assign in_rng = addr < 10'(RNG_BYTES);
  assign otp_prg = acc && (op == OP_OTP_PRG);
  assign otp_fail = otp_prg && (frz || locked || (in_rng && data != ERASED));
  assign otp_wr = otp_prg && !frz && !locked && !in_rng;

  // register command checks
  logic [4:0] ridx;
  otpsh_kind_t rk;
  logic reg_ok;
  logic reg_cmd;
  logic reg_fail;

  assign ridx = addr[4:0];
  assign rk = reg_kind(ridx);
  assign reg_ok = addr < 10'(REG_CNT);
  assign reg_cmd = acc && (op >= OP_REG_RD);

  always_comb begin
    reg_fail = 1'b0;
    if (reg_cmd) begin
      case (op)
        OP_REG_RD: reg_fail = !reg_ok;
        OP_REG_RD_NV: reg_fail = !reg_ok || !has_nv(rk);
        OP_REG_WR_NV: reg_fail = !reg_ok || rk != K_DUAL && rk != K_NV;
        OP_REG_WR_V: reg_fail = !reg_ok || !has_v(rk);
        OP_REG_PRG: reg_fail = !reg_ok || !has_nv(rk);
        default: reg_fail = 1'b0;
      endcase
    end
  end

  logic reg_hit;
  assign reg_hit = reg_cmd && !reg_fail;

  ////////////////////////////////////////////////////////////////////////
  // otp byte store

  // bits only ever go from one to zero, as in a real otp cell
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < OTP_BYTES; i++) begin
        otp_q[i] <= otp_factory(10'(i));
      end
    end else if (otp_wr) begin
      otp_q[addr] <= otp_q[addr] & data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register shadow slots

  for (genvar gi = 0; gi < REG_CNT; gi++) begin : g_reg
    localparam logic [4:0] GIDX = 5'(gi);
    localparam otpsh_kind_t GK = reg_kind(5'(gi));
    logic hit;
    logic [7:0] nv_d;
    logic [7:0] v_d;

    assign hit = reg_hit && (ridx == GIDX);

    always_comb begin
      nv_d = nv_q[gi];
      v_d = v_q[gi];
      if (loading) begin
        v_d = nv_q[gi];
      end else if (hit) begin
        case (op)
          OP_REG_WR_NV: begin
            nv_d = data;
            v_d = has_v(GK) ? data : v_q[gi];
          end
          OP_REG_WR_V: begin
            v_d = data;
          end
          OP_REG_PRG: begin
            nv_d = nv_q[gi] & data;
            v_d = has_v(GK) ? (v_q[gi] & data) : v_q[gi];
          end
          default: begin
            v_d = v_q[gi];
          end
        endcase
      end
      // only the reload may drop freeze
      if (GIDX == IDX_CR1 && !loading) begin
        v_d[FRZ_BIT] = v_d[FRZ_BIT] | v_q[gi][FRZ_BIT];
      end
      // a failing program in the cycle of a clear still flags
      if (GIDX == IDX_SR1 && otp_fail) begin
        v_d[PERR_BIT] = 1'b1;
      end
    end

    always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
        nv_q[gi] <= reg_factory(GK);
        v_q[gi] <= reg_factory(GK);
      end else if (CLK_EN_I) begin
        nv_q[gi] <= nv_d;
        v_q[gi] <= v_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer

  otpsh_rsp_t rsp_d;

  always_comb begin
    rsp_d.fail = otp_fail || reg_fail;
    rsp_d.data = 8'h00;
    case (op)
      OP_OTP_RD: rsp_d.data = otp_q[addr];
      OP_REG_RD: rsp_d.data = !reg_ok ? 8'h00 : has_v(rk) ? v_q[ridx] : nv_q[ridx];
      OP_REG_RD_NV: rsp_d.data = reg_ok ? nv_q[ridx] : 8'h00;
      default: rsp_d.data = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_O <= '0;
    end else if (CLK_EN_I) begin
      RSP_VALID_O <= acc && (op != OP_NOP);
      if (acc) begin
        RSP_O <= rsp_d;
      end
    end
  end

  // status views straight from the shadow flops
  assign FREEZE_O = v_q[IDX_CR1][FRZ_BIT];
  assign PROG_ERR_O = v_q[IDX_SR1][PERR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic [127:0] rng_now;
  for (genvar gj = 0; gj < RNG_BYTES; gj++) begin : g_rng
    assign rng_now[gj*8 +: 8] = otp_q[gj];
  end

  logic [7:0] cr2_nv;
  logic [7:0] cr3_nv;
  logic [7:0] dlr_nv;
  logic [7:0] sr1_v;
  assign cr2_nv = nv_q[IDX_CR2];
  assign cr3_nv = nv_q[IDX_CR3];
  assign dlr_nv = nv_q[IDX_DLR];
  assign sr1_v = v_q[IDX_SR1];

  a_rng_fixed: assert property ($stable(rng_now))
    else $error("random number bytes changed");

  a_rng_zero: assert property (otp_prg && in_rng && data != ERASED |=> RSP_O.fail && PROG_ERR_O)
    else $error("zero into random bytes not flagged");

  a_frz_block: assert property (otp_prg && frz |=> RSP_VALID_O && RSP_O.fail && PROG_ERR_O)
    else $error("program under freeze not rejected");

  a_lock_block: assert property (otp_prg && locked |-> !otp_wr ##1 RSP_O.fail)
    else $error("locked region accepted program");

  a_otp_and: assert property (otp_wr |=> otp_q[$past(addr)] == ($past(otp_q[addr]) & $past(data)))
    else $error("otp byte not anded with data");

  a_load_copy: assert property (loading && CLK_EN_I |=> v_q[IDX_CR2] == $past(cr2_nv))
    else $error("reload did not copy nv into volatile");

  a_nv_write: assert property (reg_hit && op == OP_REG_WR_NV && ridx == IDX_CR2 && CLK_EN_I
    |=> cr2_nv == $past(data) && v_q[IDX_CR2] == $past(data))
    else $error("nv write did not refresh volatile");

  a_vol_write: assert property (reg_hit && op == OP_REG_WR_V && ridx == IDX_CR3 && CLK_EN_I
    |=> $stable(cr3_nv) && v_q[IDX_CR3] == $past(data))
    else $error("volatile write disturbed nv copy");

  a_reg_prog: assert property (reg_hit && op == OP_REG_PRG && ridx == IDX_DLR && CLK_EN_I
    |=> dlr_nv == ($past(dlr_nv) & $past(data)))
    else $error("register program not anded");

  a_rd_vol: assert property (acc && op == OP_REG_RD && reg_ok && ridx == IDX_SR1 && !otp_fail
    |=> RSP_VALID_O && RSP_O.data == $past(sr1_v))
    else $error("read did not return volatile copy");

  a_frz_sticky: assert property ($fell(FREEZE_O) |-> $past(loading))
    else $error("freeze cleared without reload");

  // a held reset source must not reload while the enable is low
  a_en_hold: assert property (!CLK_EN_I |=> $stable(RSP_O) && $stable(BUSY_O) && $stable(FREEZE_O))
    else $error("state moved while clock enable low");

endmodule : otpsh_top

//--- tb/otpsh_host.sv
// Purpose: serial host side of the command port, one request at a time
// Assumes: called just after a rising edge of clk_i
// Notes: released command lines are inverted so stale values never look valid

`timescale 1ns/1ps

module otpsh_host
  import otpsh_pkg::*;
(
  // clock
  input wire logic clk_i,
  // answer side
  input wire logic busy_i,
  input wire logic rsp_valid_i,
  input wire otpsh_rsp_t rsp_i,
  // command side
  output logic cmd_valid_o,
  output otpsh_cmd_t cmd_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request held for up to 40 edges until one sees the block idle; answer read 1 ns after that edge
  task automatic issue(input otpsh_op_t op, input logic [9:0] addr, input logic [7:0] data,
                       output logic ok, output otpsh_rsp_t rsp);
    int n;
    logic idle;
    ok = 1'b0;
    cmd_o = '{op: op, addr: addr, data: data};
    cmd_valid_o = 1'b1;
    for (n = 0; n < 40 && !ok; n++) begin
      idle = !busy_i;
      @(posedge clk_i);
      ok = idle;
    end
    #1;
    rsp = rsp_i;
    ok = ok && rsp_valid_i;
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;
    // one idle edge so the strobe is never set twice in one step
    @(posedge clk_i);
    #1;
  endtask : issue
endmodule : otpsh_host

//--- tb/otpsh_top_test.sv
// Purpose: self-checking bench of the otp space and register shadow block
// Assumes: host model drives the command port, bench drives resets
// Notes: reference model of otp bytes and both register copies in plain arrays

`timescale 1ns/1ps

module otpsh_top_test;
  import otpsh_pkg::*;
  // arbitrary random number for the factory area
  localparam logic [127:0] RND = 128'h8899aabbccddeeff0011223344556677;
  logic sys_clk, rst_n, clk_en, hw_rst_n, soft_rst, cmd_valid, rsp_valid, busy, freeze, prog_err;
  otpsh_cmd_t cmd;
  otpsh_rsp_t rsp;
  int error_cnt = 0;
  int num_checks = 0;
  int a;
  logic [7:0] otp [1024];
  logic [7:0] nv [22];
  logic [7:0] vol [22];
  logic [31:0] lfsr = 32'h4518;

  otpsh_top #(.FACTORY_RANDOM(RND)) u_otpsh_top (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .CLK_EN_I(clk_en),
    .HW_RESET_N_I(hw_rst_n), .SOFT_RESET_I(soft_rst), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .RSP_VALID_O(rsp_valid), .RSP_O(rsp), .BUSY_O(busy), .FREEZE_O(freeze), .PROG_ERR_O(prog_err));
  otpsh_host u_otpsh_host (.clk_i(sys_clk), .busy_i(busy), .rsp_valid_i(rsp_valid), .rsp_i(rsp),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd8

  // 0 dual, 1 volatile only, 2 nv only, 3 otp, 9 unmapped
  function automatic int kind_of(int i);
    if (i > 20) return 9;
    if (i == 1 || i == 6 || i == 17 || i == 19) return 1;
    if (i >= 7 && i <= 16) return 3;
    if (i == 18) return 2;
    return 0;
  endfunction : kind_of

  task automatic reload();
    for (int i = 0; i < 22; i++) vol[i] = (kind_of(i) == 0) ? nv[i] : 8'h00;
  endtask : reload

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // model first, then the same command on the port, then compare
  task automatic run(input otpsh_op_t op, input int ad, input logic [7:0] d);
    logic ok, ef, rd;
    logic [7:0] ed;
    otpsh_rsp_t r;
    int k;
    k = kind_of(ad);
    ef = 1'b0;
    rd = 1'b0;
    ed = 8'h00;
    case (op)
      OP_OTP_RD: begin
        rd = 1'b1;
        ed = otp[ad];
      end
      OP_OTP_PRG: begin
        ef = vol[2][0] || !otp[16 + ad / 256][(ad / 32) % 8] || (ad < 16 && d != 8'hff);
        if (ef) vol[0][6] = 1'b1;
        else otp[ad] = otp[ad] & d;
      end
      OP_REG_RD: begin
        ef = k == 9;
        rd = !ef;
        ed = (k < 2) ? vol[ad] : nv[ad];
      end
      OP_REG_RD_NV: begin
        ef = k == 1 || k == 9;
        rd = !ef;
        ed = nv[ad];
      end
      OP_REG_WR_NV: begin
        ef = !(k == 0 || k == 2);
        if (!ef) nv[ad] = d;
        if (!ef && k == 0) vol[ad] = d;
      end
      OP_REG_WR_V: begin
        ef = k > 1;
        // freeze survives a clearing write
        if (!ef) vol[ad] = (ad == 2) ? (d | {7'h00, vol[2][0]}) : d;
      end
      default: begin
        ef = k == 1 || k == 9;
        if (!ef) nv[ad] = nv[ad] & d;
        if (!ef && k == 0) vol[ad] = vol[ad] & d;
      end
    endcase
    u_otpsh_host.issue(op, ad[9:0], d, ok, r);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
      stop_test();
    end
    check({7'h00, r.fail}, {7'h00, ef});
    if (rd) check(r.data, ed);
    check({6'h00, freeze, prog_err}, {6'h00, vol[2][0], vol[0][6]});
  endtask : run

  task automatic read_regs();
    for (int i = 0; i < 22; i++) run(OP_REG_RD, i, 8'h00);
    run(OP_OTP_RD, 33, 8'h00);
  endtask : read_regs

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    hw_rst_n = 1'b1;
    soft_rst = 1'b0;
    for (a = 0; a < 1024; a++) otp[a] = (a < 16) ? RND[8 * a +: 8] : 8'hff;
    for (a = 0; a < 22; a++) nv[a] = (kind_of(a) == 3) ? 8'hff : 8'h00;
    reload();
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    for (a = 0; a < 1024; a++) run(OP_OTP_RD, a, 8'h00);
    run(OP_OTP_PRG, 5, 8'hff);
    run(OP_OTP_PRG, 15, 8'hfe);
    run(OP_OTP_RD, 15, 8'h00);
    for (a = 20; a < 1024; a += 45) run(OP_OTP_PRG, a, rnd8());
    for (a = 20; a < 1024; a += 45) run(OP_OTP_PRG, a, rnd8());
    for (a = 20; a < 1024; a += 45) run(OP_OTP_RD, a, 8'h00);
    run(OP_OTP_PRG, 16, 8'hfd);
    run(OP_OTP_PRG, 19, 8'h7f);
    run(OP_OTP_PRG, 33, 8'h0f);
    run(OP_OTP_PRG, 1023, 8'h00);
    run(OP_OTP_PRG, 64, 8'h3c);
    run(OP_OTP_PRG, 16, 8'hfe);
    run(OP_OTP_PRG, 24, 8'h00);
    for (a = 1; a < 22; a++) begin
      if (a == 2) continue;
      run(OP_REG_WR_NV, a, rnd8());
      run(OP_REG_WR_V, a, rnd8());
      run(OP_REG_PRG, a, rnd8());
      run(OP_REG_RD, a, 8'h00);
      run(OP_REG_RD_NV, a, 8'h00);
    end
    // boot code freezes, then programming is rejected and freeze survives a clearing write
    run(OP_REG_WR_V, 2, 8'h01);
    run(OP_OTP_PRG, 96, 8'h00);
    run(OP_REG_WR_V, 2, 8'h00);
    run(OP_REG_RD, 2, 8'h00);
    soft_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    soft_rst = 1'b0;
    reload();
    read_regs();
    run(OP_REG_WR_V, 2, 8'h01);
    // a soft reset seen only while the enable is low must not reload
    clk_en = 1'b0;
    soft_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    soft_rst = 1'b0;
    clk_en = 1'b1;
    run(OP_REG_RD, 2, 8'h00);
    hw_rst_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    hw_rst_n = 1'b1;
    reload();
    read_regs();
    stop_test();
  end
endmodule : otpsh_top_test
